/* awd_top.sv */
// Autowake timer and watchdog service logic behind an APB slave.
`timescale 1ns/1ps
// Notes on behaviour
// - A write with the arm bit set loads the timer from the written period and resolution and arms it.
// - Entering full-power or reduced battery operation disarms the timer unless an arm write lands in that same cycle; it never counts there.
// - The sleep interval is the period count times the selected resolution unit, a count of zero giving one unit.
// - The period count resets to one and can reach at most seven.
// - Resolution one gives a minute per count, resolution zero gives 2.5 seconds.
// - The near-overflow flag sets about one millisecond before the watchdog overflows.
// - The near-overflow flag clears on a written zero or on the falling edge of wake.
// - Writing zero to the service bit clears the flag, writing one restarts the watchdog.
// - Watchdog overflow sets the expiry status, which clears while reset is high.
module awd_top #(
   parameter logic [31:0] SHORT_CYC = awd_pkg::WAKE_SHORT_CYC,
   parameter logic [31:0] LONG_CYC = awd_pkg::WAKE_LONG_CYC,
   parameter logic [31:0] LEAD_CYC = awd_pkg::WDT_LEAD_CYC,
   parameter logic [31:0] PERIOD_CYC = awd_pkg::WDT_PERIOD_CYC
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [15:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic FULL_POWER_OPERATION,
   input wire logic REDUCED_BATTERY_OPERATION,
   output logic WAKE,
   output logic ARMED,
   output logic WATCHDOG_NEAR_OVERFLOW_FLAG,
   output logic WATCHDOG_EXPIRY_STATUS,
   output logic WDT_OVERFLOW
);
   logic fp_s1, fp_s2, rb_s1, rb_s2, mode_d;
   logic mode, mode_rise;
   logic acc, wr;
   logic hit_wdt, hit_stat, hit_wake, hit_flag;
   logic next_pready, next_pslverr;
   logic [31:0] next_prdata;
   awd_pkg::awd_wake_cfg_t cfg, next_cfg;
   awd_pkg::awd_state_t state, next_state;
   logic [2:0] units, next_units;
   logic act_res, next_act_res, next_wake, next_armed;
   logic arm_wr, pre_load, pre_zero, counting, pre_res;
   logic [31:0] pre_cnt, pre_val;
   logic [31:0] wdt_cnt;
   logic wdt_zero, wdt_load, svc_wr1, svc_wr0;
   logic near_set, near_clr, wake_fall;
   logic next_near, next_exp, next_ovf;

   // Mode pins come from the power controller, outside this clock.
   always_ff @(posedge CLK) begin
      if (RST) begin
         fp_s1 <= 1'b0;
         fp_s2 <= 1'b0;
         rb_s1 <= 1'b0;
         rb_s2 <= 1'b0;
         mode_d <= 1'b0;
      end else if (CE) begin
         fp_s1 <= FULL_POWER_OPERATION;
         fp_s2 <= fp_s1;
         rb_s1 <= REDUCED_BATTERY_OPERATION;
         rb_s2 <= rb_s1;
         mode_d <= mode;
      end
   end

   assign mode = fp_s2 | rb_s2;
   assign mode_rise = mode & ~mode_d;

   // The low address bits must be zero, so a misaligned access misses all.
   assign hit_wdt = (PADDR == {awd_pkg::IDX_WDT, 2'b00});
   assign hit_stat = (PADDR == {awd_pkg::IDX_STAT, 2'b00});
   assign hit_wake = (PADDR == {awd_pkg::IDX_WAKE, 2'b00});
   assign hit_flag = (PADDR == {awd_pkg::IDX_FLAG, 2'b00});
   assign acc = PSEL & PENABLE & PREADY;
   // Only the low byte lane carries these fields.
   assign wr = acc & PWRITE & PSTRB[0];

   always_comb begin
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      next_prdata = 32'h0;
      if (PSEL && PENABLE && !PREADY) begin
         next_pready = 1'b1;
         if (hit_wake) begin
            next_prdata[awd_pkg::SLEEP_PERIOD_COUNT_LSB +: 3] = cfg.prd;
            next_prdata[awd_pkg::SLEEP_PERIOD_RESOLUTION_BIT] = cfg.res;
         end else if (hit_flag) begin
            next_prdata[awd_pkg::FLAG_NEAR_BIT] =
               WATCHDOG_NEAR_OVERFLOW_FLAG;
         end else if (hit_stat) begin
            next_prdata[awd_pkg::STAT_EXP_BIT] = WATCHDOG_EXPIRY_STATUS;
         end else if (hit_wdt) begin
            next_prdata = 32'h0;
         end else begin
            next_pslverr = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h0;
      end else if (CE) begin
         PREADY <= next_pready;
         PSLVERR <= next_pslverr;
         PRDATA <= next_prdata;
      end
   end

   assign arm_wr = wr & hit_wake & PWDATA[awd_pkg::WAKE_ARM_BIT];
   assign pre_res = arm_wr ? PWDATA[awd_pkg::SLEEP_PERIOD_RESOLUTION_BIT] : act_res;
   assign pre_val = pre_res ? LONG_CYC - 32'h1 : SHORT_CYC - 32'h1;

   always_comb begin
      next_cfg = cfg;
      next_state = state;
      next_units = units;
      next_act_res = act_res;
      next_wake = WAKE;
      next_armed = ARMED;
      pre_load = 1'b0;
      counting = 1'b0;
      if (wr && hit_wake) begin
         next_cfg.prd = PWDATA[awd_pkg::SLEEP_PERIOD_COUNT_LSB +: 3];
         next_cfg.res = PWDATA[awd_pkg::SLEEP_PERIOD_RESOLUTION_BIT];
      end
      case (state)
         awd_pkg::AWD_IDLE: begin
            next_armed = 1'b0;
         end
         awd_pkg::AWD_ARMED: begin
            if (mode_rise) begin
               next_state = awd_pkg::AWD_IDLE;
               next_armed = 1'b0;
            end else if (!mode) begin
               // Without an arm the idle state never counts.
               counting = 1'b1;
               if (pre_zero) begin
                  pre_load = 1'b1;
                  if (units <= 3'h1) begin
                     next_state = awd_pkg::AWD_WAKING;
                     next_wake = 1'b1;
                     next_armed = 1'b0;
                  end else begin
                     next_units = units - 3'h1;
                  end
               end
            end
         end
         awd_pkg::AWD_WAKING: begin
            // Wake stays up until the processor is back at full power or an arm write restarts the timer.
            if (fp_s2) begin
               next_state = awd_pkg::AWD_IDLE;
               next_wake = 1'b0;
            end
         end
         default: begin
            next_state = awd_pkg::AWD_IDLE;
         end
      endcase
      // The arm takes the byte being written, so one write sets all.
      if (arm_wr) begin
         next_state = awd_pkg::AWD_ARMED;
         next_units = PWDATA[awd_pkg::SLEEP_PERIOD_COUNT_LSB +: 3];
         next_act_res = PWDATA[awd_pkg::SLEEP_PERIOD_RESOLUTION_BIT];
         next_armed = 1'b1;
         next_wake = 1'b0;
         pre_load = 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         cfg <= '{res: awd_pkg::RES_RST, prd: awd_pkg::PRD_RST};
         state <= awd_pkg::AWD_IDLE;
         units <= awd_pkg::PRD_RST;
         act_res <= awd_pkg::RES_RST;
         WAKE <= 1'b0;
         ARMED <= 1'b0;
      end else if (CE) begin
         cfg <= next_cfg;
         state <= next_state;
         units <= next_units;
         act_res <= next_act_res;
         WAKE <= next_wake;
         ARMED <= next_armed;
      end
   end

   awd_cnt #(
      .W(32),
      .RST_VAL(32'h0)
   ) u_pre (
      .clk(CLK),
      .rst(RST),
      .ce(CE),
      .load(pre_load),
      .load_val(pre_val),
      .run(counting),
      .cnt(pre_cnt),
      .zero(pre_zero)
   );

   assign svc_wr1 = wr & hit_wdt & PWDATA[awd_pkg::WDT_SVC_BIT];
   assign svc_wr0 = wr & hit_wdt & ~PWDATA[awd_pkg::WDT_SVC_BIT];
   assign wdt_load = svc_wr1 | wdt_zero;
   assign wake_fall = WAKE & ~next_wake;

   awd_cnt #(
      .W(32),
      .RST_VAL(PERIOD_CYC - 32'h1)
   ) u_wdt (
      .clk(CLK),
      .rst(RST),
      .ce(CE),
      .load(wdt_load),
      .load_val(PERIOD_CYC - 32'h1),
      .run(1'b1),
      .cnt(wdt_cnt),
      .zero(wdt_zero)
   );

   always_comb begin
      near_set = (wdt_cnt == LEAD_CYC);
      near_clr = (wr & hit_flag & ~PWDATA[awd_pkg::FLAG_NEAR_BIT])
         | svc_wr0 | wake_fall;
      // A fresh event beats a clear in the same cycle.
      next_near = near_set | (WATCHDOG_NEAR_OVERFLOW_FLAG & ~near_clr);
      next_exp = wdt_zero | (WATCHDOG_EXPIRY_STATUS
         & ~(wr & hit_stat & ~PWDATA[awd_pkg::STAT_EXP_BIT]));
      next_ovf = wdt_zero;
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         WATCHDOG_NEAR_OVERFLOW_FLAG <= 1'b0;
         WATCHDOG_EXPIRY_STATUS <= 1'b0;
         WDT_OVERFLOW <= 1'b0;
      end else if (CE) begin
         WATCHDOG_NEAR_OVERFLOW_FLAG <= next_near;
         WATCHDOG_EXPIRY_STATUS <= next_exp;
         WDT_OVERFLOW <= next_ovf;
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   chk_arm_load: assert property (
      CE && arm_wr |=> ARMED && state == awd_pkg::AWD_ARMED
         && act_res == $past(PWDATA[awd_pkg::SLEEP_PERIOD_RESOLUTION_BIT]))
      else $error("Arm write did not arm the timer.");

   chk_mode_disarm: assert property (
      CE && mode_rise && !arm_wr |=> !ARMED && !counting)
      else $error("Timer still armed after entering a powered mode.");

   chk_units_load: assert property (
      CE && arm_wr |=> units == $past(PWDATA[2:0]))
      else $error("Period count not loaded on arm.");

   chk_prd_reset: assert property (
      $past(RST) |-> cfg.prd == awd_pkg::PRD_RST && !ARMED && !WAKE)
      else $error("Period count has wrong reset value.");

   chk_res_unit: assert property (
      CE && pre_load |=> pre_cnt ==
         (act_res ? LONG_CYC - 32'h1 : SHORT_CYC - 32'h1))
      else $error("Prescaler loaded with the wrong unit.");

   chk_near_set: assert property (
      CE && wdt_cnt == LEAD_CYC |=> WATCHDOG_NEAR_OVERFLOW_FLAG)
      else $error("Near-overflow flag missed its point.");

   chk_near_clear: assert property (
      CE && near_clr && !near_set |=> !WATCHDOG_NEAR_OVERFLOW_FLAG)
      else $error("Near-overflow flag did not clear.");

   chk_svc_restart: assert property (
      CE && svc_wr1 |=> wdt_cnt == PERIOD_CYC - 32'h1
         ##1 !WDT_OVERFLOW)
      else $error("Service write did not restart the watchdog.");

   chk_expiry_set: assert property (
      CE && wdt_zero |=> WATCHDOG_EXPIRY_STATUS && WDT_OVERFLOW)
      else $error("Overflow did not set the expiry status.");

   chk_wake_raise: assert property (
      CE && state == awd_pkg::AWD_ARMED && !mode && pre_zero
         && units <= 3'h1 && !arm_wr |=> WAKE && !ARMED
         && state == awd_pkg::AWD_WAKING)
      else $error("Expired interval did not raise wake.");

   chk_mode_hold: assert property (
      CE && mode && !pre_load |=> $stable(pre_cnt))
      else $error("Timer counted in a powered mode.");

   chk_armed_state: assert property (
      ARMED == (state == awd_pkg::AWD_ARMED))
      else $error("Armed output disagrees with the timer state.");

   chk_prd_write: assert property (
      CE && wr && hit_wake |=> cfg.prd == $past(PWDATA[2:0]))
      else $error("Period count not stored on a write.");

   chk_flag_sticky: assert property (
      CE && WATCHDOG_NEAR_OVERFLOW_FLAG && !near_clr
         |=> WATCHDOG_NEAR_OVERFLOW_FLAG)
      else $error("Near-overflow flag dropped without a clear.");

   chk_svc_clear: assert property (
      CE && svc_wr0 && !near_set |=> !WATCHDOG_NEAR_OVERFLOW_FLAG)
      else $error("Service write of zero left the flag set.");

   chk_ovf_pulse: assert property (
      CE && !wdt_zero |=> !WDT_OVERFLOW)
      else $error("Overflow pulse without an overflow.");

   chk_exp_reset: assert property (
      $past(RST) |-> !WATCHDOG_EXPIRY_STATUS && !WDT_OVERFLOW)
      else $error("Expiry status survived reset.");

   chk_near_wake: assert property (
      CE && wake_fall && !near_set |=> !WATCHDOG_NEAR_OVERFLOW_FLAG)
      else $error("Falling wake did not clear the flag.");

   chk_wake_hold: assert property (
      CE && WAKE && !fp_s2 && !arm_wr |=> WAKE)
      else $error("Wake request dropped before full power returned.");

endmodule : awd_top

/* awd_pkg.sv */
// Package with register map, field layout, reset values and timing.
package awd_pkg;

   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned WAKE_SHORT_MS = 2500;
   localparam int unsigned WAKE_LONG_MIN = 1;
   localparam int unsigned WDT_LEAD_MS = 1;
   localparam int unsigned WDT_PERIOD_MS = 1500;

   localparam logic [31:0] WAKE_SHORT_CYC =
      32'(longint'(WAKE_SHORT_MS) * longint'(CLK_HZ) / 1000);
   localparam logic [31:0] WAKE_LONG_CYC =
      32'(longint'(WAKE_LONG_MIN) * 60 * longint'(CLK_HZ));
   localparam logic [31:0] WDT_LEAD_CYC =
      32'(longint'(WDT_LEAD_MS) * longint'(CLK_HZ) / 1000);
   localparam logic [31:0] WDT_PERIOD_CYC =
      32'(longint'(WDT_PERIOD_MS) * longint'(CLK_HZ) / 1000);

   localparam logic [13:0] IDX_WDT = 14'h00f8;
   localparam logic [13:0] IDX_STAT = 14'h2002;
   localparam logic [13:0] IDX_WAKE = 14'h20a9;
   localparam logic [13:0] IDX_FLAG = 14'h20b1;

   localparam int WDT_SVC_BIT = 7;
   localparam int STAT_EXP_BIT = 2;
   localparam int WAKE_ARM_BIT = 7;
   localparam int SLEEP_PERIOD_RESOLUTION_BIT = 3;
   localparam int SLEEP_PERIOD_COUNT_LSB = 0;
   localparam int FLAG_NEAR_BIT = 0;

   localparam logic [2:0] PRD_RST = 3'h1;
   localparam logic RES_RST = 1'b0;

   typedef struct packed {
      logic res;
      logic [2:0] prd;
   } awd_wake_cfg_t;

   typedef enum logic [1:0] {
      AWD_IDLE = 2'b00,
      AWD_ARMED = 2'b01,
      AWD_WAKING = 2'b11
   } awd_state_t;

endpackage : awd_pkg

/* awd_cnt.sv */
// Loadable down counter that stops at zero.
`timescale 1ns/1ps
module awd_cnt #(
   parameter int W = 32,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   input wire logic run,
   output logic [W-1:0] cnt,
   output logic zero
);
   logic [W-1:0] next_cnt;

   always_comb begin
      next_cnt = cnt;
      if (load) begin
         next_cnt = load_val;
      end else if (run && cnt != '0) begin
         next_cnt = cnt - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt <= RST_VAL;
      end else if (ce) begin
         cnt <= next_cnt;
      end
   end

   assign zero = (cnt == '0);

endmodule : awd_cnt

/* awd_top_bench.sv */
// Self-checking bench for the autowake timer and watchdog block.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
   miscompares++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module awd_top_bench;
   localparam logic [31:0] SC = 32'h14;
   localparam logic [31:0] LC = 32'h32;
   localparam logic [31:0] LD = 32'h5;
   localparam logic [31:0] PD = 32'h28;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, psel = 1'b0, pen = 1'b0;
   logic pwr = 1'b0, fp = 1'b0, rb = 1'b0;
   logic [15:0] paddr = 16'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'h0;
   logic pready, pslverr, wake, armed, nflag, xstat, ovf, err, r;
   logic [2:0] p;
   int miscompares = 0, num_checks = 0, seed = 32'h5e1b0192;
   int novf = 0, n, m, e;

   awd_top #(.SHORT_CYC(SC), .LONG_CYC(LC), .LEAD_CYC(LD),
      .PERIOD_CYC(PD)) u_awd_top (.CLK(clk), .RST(rst), .CE(ce),
      .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
      .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr),
      .FULL_POWER_OPERATION(fp), .REDUCED_BATTERY_OPERATION(rb),
      .WAKE(wake), .ARMED(armed), .WATCHDOG_NEAR_OVERFLOW_FLAG(nflag),
      .WATCHDOG_EXPIRY_STATUS(xstat), .WDT_OVERFLOW(ovf));

   always #20 clk = ~clk;
   always @(posedge clk) begin
      if (ovf === 1'b1) novf <= novf + 1;
   end

   task automatic close_out;
      if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out

   // Each write carries whole byte lanes or none at all, never a lone bit.
   task automatic apb(input logic w, input logic [13:0] idx,
      input logic [31:0] d, input logic [3:0] s);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         miscompares++;
         close_out;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb

   function automatic logic sel(input int w);
      case (w)
         0: return wake;
         1: return armed;
         2: return nflag;
         default: return ovf;
      endcase
   endfunction : sel

   task automatic wt(input int w, input logic v, input int lim);
      n = 0;
      while (sel(w) !== v) begin
         @(posedge clk);
         n++;
         if (n > lim) begin
            miscompares++;
            close_out;
         end
      end
   endtask : wt

   function automatic int iv(input logic [2:0] c, input logic u);
      return int'(c) * int'(u ? LC : SC);
   endfunction : iv

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, awd_pkg::IDX_WAKE, 32'h0, 4'h0);
      `CHK(rd, 32'h1)
      apb(1'b0, 14'h0001, 32'h0, 4'h0);
      `CHK({err, rd}, 33'h100000000)
      apb(1'b1, awd_pkg::IDX_WAKE, 32'h5, 4'h0);
      apb(1'b0, awd_pkg::IDX_WAKE, 32'h0, 4'h0);
      `CHK(rd, 32'h1)
      for (int i = 0; i < 4; i++) begin
         p = (i == 0) ? 3'h7 : (i == 1) ? 3'h1 :
            3'(($unsigned($random(seed)) % 7) + 1);
         r = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($random(seed));
         apb(1'b1, awd_pkg::IDX_WAKE, {24'h0, 4'h8, r, p}, 4'h1);
         wt(1, 1'b1, 3);
         m = n;
         `CHK(armed, 1'b1)
         wt(0, 1'b1, 400);
         e = iv(p, r);
         `CHK(m + n >= e - 1 && m + n <= e + 4, 1'b1)
         `CHK(armed, 1'b0)
         apb(1'b0, awd_pkg::IDX_WAKE, 32'h0, 4'h0);
         `CHK(rd, {28'h0, r, p})
         fp <= 1'b1;
         wt(0, 1'b0, 8);
         fp <= 1'b0;
         repeat (4) @(posedge clk);
      end
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, awd_pkg::IDX_WAKE, 32'h81, 4'h1);
         if (k == 0) rb <= 1'b1;
         else fp <= 1'b1;
         @(posedge clk);
         `CHK(armed, 1'b1)
         wt(1, 1'b0, 8);
         `CHK(armed, 1'b0)
         repeat (40) @(posedge clk);
         `CHK(wake, 1'b0)
         rb <= 1'b0;
         fp <= 1'b0;
         repeat (4) @(posedge clk);
      end
      // Restart first so the flag cannot come back before it is looked at.
      apb(1'b1, awd_pkg::IDX_WDT, 32'h80, 4'h1);
      apb(1'b1, awd_pkg::IDX_FLAG, 32'h0, 4'h1);
      apb(1'b1, awd_pkg::IDX_STAT, 32'h0, 4'h1);
      @(posedge clk);
      `CHK(nflag, 1'b0)
      `CHK(xstat, 1'b0)
      wt(2, 1'b1, 60);
      `CHK(n >= PD - LD - 9 && n <= PD - LD, 1'b1)
      wt(3, 1'b1, 10);
      `CHK(n >= LD - 1 && n <= LD + 1, 1'b1)
      @(posedge clk);
      `CHK(xstat, 1'b1)
      apb(1'b0, awd_pkg::IDX_FLAG, 32'h0, 4'h0);
      `CHK(rd, 32'h1)
      apb(1'b1, awd_pkg::IDX_WDT, 32'h0, 4'h1);
      @(posedge clk);
      `CHK(nflag, 1'b0)
      m = novf;
      repeat (15) apb(1'b1, awd_pkg::IDX_WDT, 32'h80, 4'h1);
      `CHK(novf, m)
      // With the enable low the watchdog must not reach its overflow.
      ce <= 1'b0;
      repeat (60) @(posedge clk);
      `CHK(novf, m)
      `CHK(ovf, 1'b0)
      ce <= 1'b1;
      apb(1'b0, awd_pkg::IDX_STAT, 32'h0, 4'h0);
      `CHK(rd[2], 1'b1)
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK(xstat, 1'b0)
      rst <= 1'b0;
      close_out;
   end
endmodule : awd_top_bench
